// [verilog/rpms_pkg.sv]
// constants and types for the receiver power-mode sequencer
// assumes a 10 MHz system clock and firmware-side status flags on the same clock
`default_nettype none
package rpms_pkg;
	localparam int CLK_NS = 100;
	localparam int CLK_HZ = 10_000_000;
	// wake pulse window
	localparam int WAKE_MIN_NS = 62_000;
	localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_MAX_S = 1;
	localparam int WAKE_MAX_CYC = WAKE_MAX_S * CLK_HZ;
	localparam int WAKE_CW = 24;
	// manual reset qualification
	localparam int RST_HOLD_NS = 1_000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] RST_HOLD = 4'(RST_HOLD_CYC);
	// rtc seconds and wake period
	localparam int SEC_CYC = CLK_HZ;
	localparam int SEC_CW = 24;
	localparam int PER_W = 13;
	localparam logic [PER_W-1:0] PER_DEF_S = 13'h0708;
	localparam logic [PER_W-1:0] PER_MIN_S = 13'h000A;
	localparam logic [PER_W-1:0] PER_MAX_S = 13'h1C20;
	// mode select codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ADAPT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	// start type codes
	localparam logic [1:0] START_COLD = 2'h0;
	localparam logic [1:0] START_WARM = 2'h1;
	localparam logic [1:0] START_HOT = 2'h2;
	typedef enum logic [2:0] {
		ST_NORMAL, ST_HIB, ST_AD_FULL, ST_AD_CPU, ST_AD_STBY, ST_PW_FULL, ST_PW_HIB
	} rpms_state_t;
endpackage
`default_nettype wire

// [verilog/rpms_wake_if.sv]
// carrier for the qualified wake event between detector and sequencer
// assumes both ends on the system clock
`default_nettype none
interface rpms_wake_if;
	logic valid;
	modport det (output valid);
	modport seq (input valid);
endinterface
`default_nettype wire

// [verilog/rpms_wake_det.sv]
// wake pin synchroniser and pulse-width qualifier
// assumes the wake pin is asynchronous to the system clock
`default_nettype none
module rpms_wake_det #(
	parameter int MAX_CYC = rpms_pkg::WAKE_MAX_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin and event
	input wire logic wake_pin,
	rpms_wake_if.det wk
);
	localparam int CW = rpms_pkg::WAKE_CW;
	localparam logic [CW-1:0] MAXC = CW'(MAX_CYC);
	localparam logic [CW-1:0] MINC = CW'(rpms_pkg::WAKE_MIN_CYC);

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic [rpms_pkg::WAKE_CW-1:0] cnt;
		logic pulse;
	} rpms_det_t;

	rpms_det_t s, next_s;

	// count high time; saturate so a stuck-high pin never wraps into the window
	always_comb begin
		next_s = s;
		next_s.s1 = wake_pin;
		next_s.s2 = s.s1;
		next_s.prev = s.s2;
		next_s.pulse = 1'b0;
		if (s.s2) begin
			if (s.cnt != MAXC)
				next_s.cnt = s.cnt + 1'b1;
		end else begin
			next_s.cnt = '0;
			// falling edge closes the pulse
			if (s.prev && s.cnt > MINC && s.cnt < MAXC)
				next_s.pulse = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign wk.valid = s.pulse;

	AST_WAKE_WIDTH: assert property (@(posedge clk) disable iff (rst)
		s.pulse |-> $past(s.cnt) > MINC && $past(s.cnt) < MAXC && !$past(s.s2))
		else $error("wake pulse accepted outside width window");
	AST_WAKE_EDGE: assert property (@(posedge clk) disable iff (rst)
		$rose(s.pulse) |-> $past(s.prev) && !$past(s.s2))
		else $error("wake pulse without synchronised falling edge");
endmodule
`default_nettype wire

// [verilog/rpms_seq.sv]
// power-mode sequencer: mode state machine, wake period timer, start type
// assumes status flags from firmware on the system clock; pins are asynchronous
`default_nettype none
module rpms_seq #(
	parameter int SEC_CYC = rpms_pkg::SEC_CYC,
	parameter int WAKE_MAX_CYC = rpms_pkg::WAKE_MAX_CYC
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// host pins
	input wire logic MANUAL_RESET_LOW,
	input wire logic WAKE_IN,
	// mode and period configuration
	input wire logic [1:0] MODE_SEL,
	input wire logic PERIOD_WR,
	input wire logic [12:0] PERIOD_SEC,
	// navigation status
	input wire logic POS_VALID,
	input wire logic VEL_VALID,
	input wire logic TIME_VALID,
	input wire logic EPH_VALID,
	input wire logic MEAS_ACQUIRED,
	input wire logic NAV_COMPUTED,
	input wire logic FIX_RELIABLE,
	// power controls
	output logic RF_DSP_FULL,
	output logic RF_DSP_PART,
	output logic BB_PWR_EN,
	output logic BB_CLK_EN,
	output logic ACQ_EN,
	// status
	output logic [2:0] STATE_CODE,
	output logic [1:0] START_TYPE,
	output logic ALMANAC_SEL,
	output logic [12:0] PERIOD_NOW,
	output logic RTC_CLEAR
);
	localparam int SCW = rpms_pkg::SEC_CW;
	localparam logic [SCW-1:0] SEC_LAST = SCW'(SEC_CYC - 1);

	typedef struct packed {
		rpms_pkg::rpms_state_t state;
		logic rs1;
		logic rs2;
		logic [3:0] rcnt;
		logic [rpms_pkg::SEC_CW-1:0] sec_cnt;
		logic [12:0] per_sec;
		logic [12:0] per_cnt;
		logic rf_full;
		logic rf_part;
		logic bb_pwr;
		logic bb_clk;
		logic acq;
		logic [1:0] start;
		logic alm;
		logic rtc_clr;
	} rpms_seq_t;

	rpms_seq_t s, next_s;
	rpms_wake_if wk ();
	logic tick;
	logic rst_held;
	logic [1:0] cls;

	rpms_wake_det #(.MAX_CYC(WAKE_MAX_CYC)) u_det (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.wake_pin(WAKE_IN),
		.wk(wk)
	);

	// start classification from stored validity; velocity missing falls back to warm
	always_comb begin
		if (!POS_VALID || !TIME_VALID)
			cls = rpms_pkg::START_COLD;
		else if (!EPH_VALID || !VEL_VALID)
			cls = rpms_pkg::START_WARM;
		else
			cls = rpms_pkg::START_HOT;
	end

	// next state of everything
	always_comb begin
		next_s = s;
		next_s.rtc_clr = 1'b0;
		tick = 1'b0;
		// reset pin must stay low the full hold time to count
		next_s.rs1 = MANUAL_RESET_LOW;
		next_s.rs2 = s.rs1;
		if (s.rs2)
			next_s.rcnt = '0;
		else if (s.rcnt != rpms_pkg::RST_HOLD)
			next_s.rcnt = s.rcnt + 1'b1;
		rst_held = (s.rcnt == rpms_pkg::RST_HOLD);
		// always-on seconds counter
		if (s.sec_cnt == SEC_LAST) begin
			next_s.sec_cnt = '0;
			tick = 1'b1;
		end else begin
			next_s.sec_cnt = s.sec_cnt + 1'b1;
		end
		// period programming, clamped into the legal range
		if (PERIOD_WR) begin
			if (PERIOD_SEC < rpms_pkg::PER_MIN_S)
				next_s.per_sec = rpms_pkg::PER_MIN_S;
			else if (PERIOD_SEC > rpms_pkg::PER_MAX_S)
				next_s.per_sec = rpms_pkg::PER_MAX_S;
			else
				next_s.per_sec = PERIOD_SEC;
		end
		if (s.state == rpms_pkg::ST_PW_HIB && tick && s.per_cnt != '0)
			next_s.per_cnt = s.per_cnt - 1'b1;
		// mode state machine
		unique case (s.state)
			rpms_pkg::ST_NORMAL: begin
				if (wk.valid)
					next_s.state = rpms_pkg::ST_HIB;
			end
			rpms_pkg::ST_HIB: begin
				if (wk.valid) begin
					unique case (MODE_SEL)
						rpms_pkg::MODE_ADAPT: next_s.state = rpms_pkg::ST_AD_FULL;
						rpms_pkg::MODE_PERIODIC: next_s.state = rpms_pkg::ST_PW_FULL;
						default: next_s.state = rpms_pkg::ST_NORMAL;
					endcase
				end
			end
			rpms_pkg::ST_AD_FULL: begin
				if (wk.valid)
					next_s.state = rpms_pkg::ST_HIB;
				else if (FIX_RELIABLE)
					next_s.state = rpms_pkg::ST_AD_STBY;
				else if (MEAS_ACQUIRED && !NAV_COMPUTED && s.start == rpms_pkg::START_HOT)
					next_s.state = rpms_pkg::ST_AD_CPU;
			end
			rpms_pkg::ST_AD_CPU: begin
				if (wk.valid)
					next_s.state = rpms_pkg::ST_HIB;
				else if (NAV_COMPUTED)
					next_s.state = rpms_pkg::ST_AD_STBY;
			end
			rpms_pkg::ST_AD_STBY: begin
				if (wk.valid)
					next_s.state = rpms_pkg::ST_HIB;
				else if (tick)
					next_s.state = rpms_pkg::ST_AD_FULL; // duty cycle restart each second
			end
			rpms_pkg::ST_PW_FULL: begin
				if (FIX_RELIABLE) begin
					next_s.state = rpms_pkg::ST_PW_HIB;
					next_s.per_cnt = s.per_sec - 1'b1;
				end
			end
			rpms_pkg::ST_PW_HIB: begin
				if (wk.valid) begin
					next_s.state = rpms_pkg::ST_PW_FULL;
					next_s.per_sec = rpms_pkg::PER_DEF_S;
				end else if (tick && s.per_cnt == '0) begin
					next_s.state = rpms_pkg::ST_PW_FULL;
				end
			end
		endcase
		// a mode change in any state but ST_HIB, in a cycle without a wake event, jumps to the new mode's entry state
		if (s.state != rpms_pkg::ST_HIB && !wk.valid) begin
			unique case (MODE_SEL)
				rpms_pkg::MODE_ADAPT:
					if (s.state inside {rpms_pkg::ST_NORMAL, rpms_pkg::ST_PW_FULL,
							rpms_pkg::ST_PW_HIB})
						next_s.state = rpms_pkg::ST_AD_FULL;
				rpms_pkg::MODE_PERIODIC:
					if (!(s.state inside {rpms_pkg::ST_PW_FULL, rpms_pkg::ST_PW_HIB}))
						next_s.state = rpms_pkg::ST_PW_FULL;
				default:
					if (s.state != rpms_pkg::ST_NORMAL)
						next_s.state = rpms_pkg::ST_NORMAL;
			endcase
		end
		// qualified manual reset restores defaults and clears the rtc
		if (rst_held) begin
			next_s.state = rpms_pkg::ST_NORMAL;
			next_s.per_sec = rpms_pkg::PER_DEF_S;
			next_s.per_cnt = '0;
			next_s.sec_cnt = '0;
			next_s.rtc_clr = 1'b1;
		end
		// latch start type whenever acquisition begins afresh
		if (next_s.state != s.state && next_s.state inside {rpms_pkg::ST_NORMAL,
				rpms_pkg::ST_PW_FULL} || (next_s.state == rpms_pkg::ST_AD_FULL
				&& s.state != rpms_pkg::ST_AD_STBY && s.state != rpms_pkg::ST_AD_FULL)) begin
			next_s.start = cls;
			next_s.alm = (cls == rpms_pkg::START_COLD);
		end
		// power decode from the state being entered, so outputs stay registered
		next_s.rf_full = 1'b0;
		next_s.rf_part = 1'b0;
		next_s.bb_pwr = 1'b0;
		next_s.bb_clk = 1'b0;
		next_s.acq = 1'b0;
		unique case (next_s.state)
			rpms_pkg::ST_NORMAL, rpms_pkg::ST_AD_FULL, rpms_pkg::ST_PW_FULL: begin
				next_s.rf_full = 1'b1;
				next_s.bb_pwr = 1'b1;
				next_s.bb_clk = 1'b1;
				next_s.acq = 1'b1;
			end
			rpms_pkg::ST_AD_CPU: begin
				next_s.rf_part = 1'b1;
				next_s.bb_pwr = 1'b1;
				next_s.bb_clk = 1'b1;
			end
			rpms_pkg::ST_AD_STBY:
				next_s.bb_pwr = 1'b1;
			rpms_pkg::ST_HIB, rpms_pkg::ST_PW_HIB:
				next_s.bb_pwr = 1'b0;
		endcase
	end

	// single state register; reset values mirror the normal-mode defaults
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			s <= '0;
			s.state <= rpms_pkg::ST_NORMAL;
			s.rs1 <= 1'b1;
			s.rs2 <= 1'b1;
			s.per_sec <= rpms_pkg::PER_DEF_S;
			s.rf_full <= 1'b1;
			s.bb_pwr <= 1'b1;
			s.bb_clk <= 1'b1;
			s.acq <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign RF_DSP_FULL = s.rf_full;
	assign RF_DSP_PART = s.rf_part;
	assign BB_PWR_EN = s.bb_pwr;
	assign BB_CLK_EN = s.bb_clk;
	assign ACQ_EN = s.acq;
	assign STATE_CODE = s.state;
	assign START_TYPE = s.start;
	assign ALMANAC_SEL = s.alm;
	assign PERIOD_NOW = s.per_sec;
	assign RTC_CLEAR = s.rtc_clr;

	AST_STBY_CLK: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		s.state == rpms_pkg::ST_AD_STBY |-> !BB_CLK_EN && !RF_DSP_FULL && !RF_DSP_PART)
		else $error("standby with rf or baseband clock on");
	AST_HIB_OFF: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		s.state inside {rpms_pkg::ST_HIB, rpms_pkg::ST_PW_HIB} |-> !BB_PWR_EN && !BB_CLK_EN)
		else $error("hibernate with baseband powered");
	AST_PER_RANGE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		PERIOD_NOW >= rpms_pkg::PER_MIN_S && PERIOD_NOW <= rpms_pkg::PER_MAX_S)
		else $error("wake period out of range");
	AST_PW_WAKE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		s.state == rpms_pkg::ST_PW_HIB && wk.valid && !rst_held |=>
		s.state == rpms_pkg::ST_PW_FULL && PERIOD_NOW == rpms_pkg::PER_DEF_S)
		else $error("wake toggle did not restart periodic cycle");
	AST_AD_HOLD: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		s.state == rpms_pkg::ST_AD_FULL && !FIX_RELIABLE && !wk.valid && !rst_held
		&& MODE_SEL == rpms_pkg::MODE_ADAPT |=> s.state != rpms_pkg::ST_AD_STBY)
		else $error("left full power before reliable fix");
	AST_RST_CLEAR: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		RTC_CLEAR |-> $past(s.rcnt) == rpms_pkg::RST_HOLD && s.state == rpms_pkg::ST_NORMAL)
		else $error("rtc clear without qualified reset");
	AST_COLD: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		$changed(START_TYPE) && START_TYPE == rpms_pkg::START_COLD |-> ALMANAC_SEL
		&& (!$past(POS_VALID) || !$past(TIME_VALID)))
		else $error("cold start misclassified");
	AST_NORMAL_ACQ: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		s.state == rpms_pkg::ST_NORMAL |-> ACQ_EN && RF_DSP_FULL && BB_CLK_EN)
		else $error("normal mode not fully powered");
endmodule
`default_nettype wire

// [bench/rpms_host.sv]
// host model: wake pin pulses and manual reset pin
// assumes the bench clock; pins change only at rising edges
`default_nettype none
module rpms_host (
	// clock
	input wire logic clk,
	// host pins
	output logic wake,
	output logic reset_low
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle levels: wake low, reset pin pulled up
	initial begin
		wake = 1'b0;
		reset_low = 1'b1;
	end
	// low-high-low pulse, high for cyc cycles
	task automatic pulse(input int cyc);
		@(posedge clk) wake <= 1'b1;
		repeat (cyc) @(posedge clk);
		wake <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// reset pin level; caller times the hold
	task automatic set_reset(input logic v);
		@(posedge clk) reset_low <= v;
	endtask
endmodule
`default_nettype wire

// [bench/rpms_seq_tb_top.sv]
// self-checking bench for the power-mode sequencer
// assumes rpms_pkg compiled first; host model drives wake and reset pins
`default_nettype none
module rpms_seq_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SEC = 20;
	logic CLK_SYS = 1'b0;
	logic SYS_RST = 1'b1;
	logic [1:0] MODE_SEL;
	logic PERIOD_WR;
	logic [12:0] PERIOD_SEC;
	logic POS_VALID, VEL_VALID, TIME_VALID, EPH_VALID;
	logic MEAS_ACQUIRED, NAV_COMPUTED, FIX_RELIABLE;
	wire logic WAKE_IN, MANUAL_RESET_LOW;
	logic RF_DSP_FULL, RF_DSP_PART, BB_PWR_EN, BB_CLK_EN, ACQ_EN, ALMANAC_SEL, RTC_CLEAR;
	logic [2:0] STATE_CODE;
	logic [1:0] START_TYPE;
	logic [12:0] PERIOD_NOW;
	logic rtc_seen = 1'b0;
	int bad_count = 0;
	int check_count = 0;
	wire logic [4:0] pwr;
	assign pwr = {RF_DSP_FULL, RF_DSP_PART, BB_PWR_EN, BB_CLK_EN, ACQ_EN};
	// 100 ns clock
	always #50 CLK_SYS = ~CLK_SYS;
	// clear stays high only while the reset pin is held low after qualification, so latch it
	always @(posedge CLK_SYS) if (RTC_CLEAR === 1'b1) rtc_seen <= 1'b1;
	// short second keeps the wake period runs brief
	rpms_seq #(.SEC_CYC(SEC), .WAKE_MAX_CYC(2000)) dut (
		.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .MANUAL_RESET_LOW(MANUAL_RESET_LOW),
		.WAKE_IN(WAKE_IN), .MODE_SEL(MODE_SEL), .PERIOD_WR(PERIOD_WR),
		.PERIOD_SEC(PERIOD_SEC), .POS_VALID(POS_VALID), .VEL_VALID(VEL_VALID),
		.TIME_VALID(TIME_VALID), .EPH_VALID(EPH_VALID), .MEAS_ACQUIRED(MEAS_ACQUIRED),
		.NAV_COMPUTED(NAV_COMPUTED), .FIX_RELIABLE(FIX_RELIABLE),
		.RF_DSP_FULL(RF_DSP_FULL), .RF_DSP_PART(RF_DSP_PART), .BB_PWR_EN(BB_PWR_EN),
		.BB_CLK_EN(BB_CLK_EN), .ACQ_EN(ACQ_EN), .STATE_CODE(STATE_CODE),
		.START_TYPE(START_TYPE), .ALMANAC_SEL(ALMANAC_SEL), .PERIOD_NOW(PERIOD_NOW),
		.RTC_CLEAR(RTC_CLEAR));
	rpms_host host (.clk(CLK_SYS), .wake(WAKE_IN), .reset_low(MANUAL_RESET_LOW));
	task automatic close_out();
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// sample just after an edge, once its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	// bounded wait for a state; running out ends the run
	task automatic wait_state(input logic [2:0] code, input int bound);
		int n;
		n = 0;
		while (STATE_CODE !== code && n < bound) begin
			cyc(1);
			n++;
		end
		chk(16'(STATE_CODE), 16'(code));
		// a state reached on the last try still counts as reached
		if (STATE_CODE !== code) close_out();
	endtask
	task automatic per_wr(input logic [12:0] v, input logic [12:0] exp);
		@(posedge CLK_SYS);
		PERIOD_SEC <= v;
		PERIOD_WR <= 1'b1;
		@(posedge CLK_SYS);
		PERIOD_WR <= 1'b0;
		cyc(2);
		chk(16'(PERIOD_NOW), 16'(exp));
	endtask
	task automatic t_reset();
		chk(16'(STATE_CODE), 16'h0000);
		chk(16'(pwr), 16'h0017);
		chk(16'(PERIOD_NOW), 16'h0708);
	endtask
	task automatic t_wake();
		host.pulse(300);
		cyc(10);
		chk(16'(STATE_CODE), 16'h0000);
		host.pulse(2100);
		cyc(10);
		chk(16'(STATE_CODE), 16'h0000);
		host.pulse(700);
		wait_state(3'h1, 20);
		chk(16'(pwr), 16'h0000);
		host.pulse(700);
		wait_state(3'h0, 20);
		chk(16'(pwr), 16'h0017);
	endtask
	task automatic t_adapt();
		@(posedge CLK_SYS);
		{POS_VALID, VEL_VALID, TIME_VALID, EPH_VALID} <= 4'hF;
		MODE_SEL <= 2'h1;
		wait_state(3'h2, 4);
		cyc(3 * SEC);
		chk(16'(STATE_CODE), 16'h0002);
		chk(16'(START_TYPE), 16'h0002);
		@(posedge CLK_SYS) MEAS_ACQUIRED <= 1'b1;
		wait_state(3'h3, 4);
		chk(16'({RF_DSP_FULL, RF_DSP_PART}), 16'h0001);
		@(posedge CLK_SYS) NAV_COMPUTED <= 1'b1;
		wait_state(3'h4, 4);
		chk(16'({RF_DSP_FULL, RF_DSP_PART, BB_CLK_EN}), 16'h0000);
		@(posedge CLK_SYS);
		MEAS_ACQUIRED <= 1'b0;
		NAV_COMPUTED <= 1'b0;
		wait_state(3'h2, 2 * SEC + 4);
		@(posedge CLK_SYS) FIX_RELIABLE <= 1'b1;
		wait_state(3'h4, 4);
		@(posedge CLK_SYS) FIX_RELIABLE <= 1'b0;
	endtask
	task automatic t_periodic();
		per_wr(13'h0005, 13'h000A);
		per_wr(13'h1C21, 13'h1C20);
		per_wr(13'h000A, 13'h000A);
		@(posedge CLK_SYS) MODE_SEL <= 2'h2;
		wait_state(3'h5, 4);
		cyc(2 * SEC);
		chk(16'(STATE_CODE), 16'h0005);
		@(posedge CLK_SYS) FIX_RELIABLE <= 1'b1;
		wait_state(3'h6, 4);
		chk(16'(pwr), 16'h0000);
		@(posedge CLK_SYS) FIX_RELIABLE <= 1'b0;
		cyc(9 * SEC - 8);
		chk(16'(STATE_CODE), 16'h0006);
		wait_state(3'h5, 2 * SEC + 8);
		// long period so the timer cannot end hibernate before the wake pulse does
		per_wr(13'h0064, 13'h0064);
		@(posedge CLK_SYS) FIX_RELIABLE <= 1'b1;
		wait_state(3'h6, 4);
		@(posedge CLK_SYS) FIX_RELIABLE <= 1'b0;
		host.pulse(700);
		wait_state(3'h5, 20);
		chk(16'(PERIOD_NOW), 16'h0708);
	endtask
	// stored-data validity is latched on re-entry to normal mode
	task automatic start_case(input logic [3:0] pvte, input logic [1:0] exp);
		@(posedge CLK_SYS);
		{POS_VALID, VEL_VALID, TIME_VALID, EPH_VALID} <= pvte;
		MODE_SEL <= 2'h1;
		@(posedge CLK_SYS) MODE_SEL <= 2'h0;
		cyc(3);
		chk(16'(START_TYPE), 16'(exp));
		chk(16'(ALMANAC_SEL), 16'(exp == 2'h0));
	endtask
	task automatic t_start();
		start_case(4'h7, 2'h0);
		start_case(4'hD, 2'h0);
		start_case(4'hE, 2'h1);
		start_case(4'hB, 2'h1);
		start_case(4'hF, 2'h2);
	endtask
	task automatic t_mreset();
		per_wr(13'h000A, 13'h000A);
		host.set_reset(1'b0);
		cyc(5);
		host.set_reset(1'b1);
		cyc(6);
		chk(16'({rtc_seen, PERIOD_NOW}), 16'h000A);
		host.set_reset(1'b0);
		cyc(16);
		host.set_reset(1'b1);
		cyc(1);
		chk(16'({rtc_seen, PERIOD_NOW}), 16'h2708);
		wait_state(3'h0, 6);
	endtask
	// main sequence
	initial begin
		// idle levels before the first edge
		MODE_SEL <= 2'h0;
		PERIOD_WR <= 1'b0;
		PERIOD_SEC <= 13'h0000;
		{POS_VALID, VEL_VALID, TIME_VALID, EPH_VALID} <= 4'h0;
		{MEAS_ACQUIRED, NAV_COMPUTED, FIX_RELIABLE} <= 3'h0;
		repeat (4) @(posedge CLK_SYS);
		SYS_RST <= 1'b0;
		cyc(2);
		t_reset();
		t_wake();
		t_adapt();
		t_periodic();
		t_start();
		t_mreset();
		close_out();
	end
endmodule
`default_nettype wire
